//--- cap_regs.svh
// register offsets, field positions and reset values of the pin multiplexer
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH

// register indices; byte address is four times the index
`define CAP_IDX_SEL      16'h1c00
`define CAP_IDX_PULL1    16'h1c17
`define CAP_IDX_PULL2    16'h1c18
`define CAP_IDX_PULL3    16'h1c19
`define CAP_ADDR_SEL     (`CAP_IDX_SEL << 2)
`define CAP_ADDR_PULL1   (`CAP_IDX_PULL1 << 2)
`define CAP_ADDR_PULL2   (`CAP_IDX_PULL2 << 2)
`define CAP_ADDR_PULL3   (`CAP_IDX_PULL3 << 2)

// external_bus_select_reg fields
`define CAP_SEL0_LSB     0
`define CAP_SEL0_MSB     1
`define CAP_SEL1_LSB     2
`define CAP_SEL1_MSB     3
`define CAP_ASEL_LSB     4
`define CAP_ASEL_MSB     9

// pull_inhibit_bank1 fields
`define CAP_PI0_LSB      0
`define CAP_PI0_MSB      5
`define CAP_PI1_LSB      6
`define CAP_PI1_MSB      11

`define CAP_SEL_RST      16'h0000
`define CAP_PULL_RST     16'h0000

`endif

//--- cap_pkg.sv
// types shared by the pin multiplexer modules
package cap_pkg;
    typedef enum logic [1:0] {
        CAP_MODE_CARD,
        CAP_MODE_AUDIO,
        CAP_MODE_GPIO,
        CAP_MODE_RSVD
    } cap_mode_t;

    typedef enum logic [2:0] {
        CAP_R_NONE,
        CAP_R_SEL,
        CAP_R_PULL1,
        CAP_R_PULL2,
        CAP_R_PULL3
    } cap_reg_t;

    typedef logic [5:0]  cap_six_t;
    typedef logic [15:0] cap_word_t;
endpackage

//--- cap_pin_slice.sv
// combinational routing of one group of six shared card/audio pins
`timescale 1ns/1ps
module cap_pin_slice (
    input  wire cap_pkg::cap_mode_t mode,
    input  wire cap_pkg::cap_six_t  cardOut,
    input  wire cap_pkg::cap_six_t  cardOe,
    output cap_pkg::cap_six_t       cardIn,
    input  wire logic [3:0]         audioOut,
    input  wire logic [3:0]         audioOe,
    output logic [3:0]              audioIn,
    input  wire cap_pkg::cap_six_t  gpioOut,
    input  wire cap_pkg::cap_six_t  gpioOe,
    output cap_pkg::cap_six_t       gpioIn,
    input  wire cap_pkg::cap_six_t  pinIn,
    output cap_pkg::cap_six_t       pinOut,
    output cap_pkg::cap_six_t       pinOe
);
    import cap_pkg::*;

    // unselected functions see a low input
    always_comb begin
        cardIn  = 6'h00;
        audioIn = 4'h0;
        gpioIn  = 6'h00;
        case (mode)
            CAP_MODE_AUDIO: begin
                pinOut  = {gpioOut[5:4], audioOut};
                pinOe   = {gpioOe[5:4], audioOe};
                audioIn = pinIn[3:0];
                gpioIn  = {pinIn[5:4], 4'h0};
            end
            CAP_MODE_GPIO: begin
                pinOut = gpioOut;
                pinOe  = gpioOe;
                gpioIn = pinIn;
            end
            // reserved code keeps the card routing
            default: begin
                pinOut = cardOut;
                pinOe  = cardOe;
                cardIn = pinIn;
            end
        endcase
    end
endmodule

//--- cap_pin_mux.sv
// card/audio/address pin multiplexer with its APB register file
`timescale 1ns/1ps
`include "cap_regs.svh"

module cap_pin_mux (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [15:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cap_pkg::cap_six_t card0Out,
    input  wire cap_pkg::cap_six_t card0Oe,
    output cap_pkg::cap_six_t      card0In,
    input  wire logic [3:0]        audio0Out,
    input  wire logic [3:0]        audio0Oe,
    output logic [3:0]             audio0In,
    input  wire cap_pkg::cap_six_t card1Out,
    input  wire cap_pkg::cap_six_t card1Oe,
    output cap_pkg::cap_six_t      card1In,
    input  wire logic [3:0]        audio1Out,
    input  wire logic [3:0]        audio1Oe,
    output logic [3:0]             audio1In,
    input  wire logic [11:0]       gpioOut,
    input  wire logic [11:0]       gpioOe,
    output logic [11:0]            gpioIn,
    input  wire cap_pkg::cap_six_t p0PinIn,
    output cap_pkg::cap_six_t      p0PinOut,
    output cap_pkg::cap_six_t      p0PinOe,
    output cap_pkg::cap_six_t      p0PullDownEn,
    input  wire cap_pkg::cap_six_t p1PinIn,
    output cap_pkg::cap_six_t      p1PinOut,
    output cap_pkg::cap_six_t      p1PinOe,
    output cap_pkg::cap_six_t      p1PullDownEn,
    input  wire cap_pkg::cap_six_t addrOut,
    input  wire cap_pkg::cap_six_t addrOe,
    input  wire cap_pkg::cap_six_t gpioHiOut,
    input  wire cap_pkg::cap_six_t gpioHiOe,
    output cap_pkg::cap_six_t      gpioHiIn,
    input  wire cap_pkg::cap_six_t addrPinIn,
    output cap_pkg::cap_six_t      addrPinOut,
    output cap_pkg::cap_six_t      addrPinOe,
    output cap_pkg::cap_word_t     pullBank2,
    output cap_pkg::cap_word_t     pullBank3
);
    import cap_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    cap_word_t   sel_q, sel_d;
    cap_word_t   pull1_q, pull1_d;
    cap_word_t   pull2_q, pull2_d;
    cap_word_t   pull3_q, pull3_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    cap_reg_t    hit;

    function automatic cap_reg_t capDecode(input logic [15:0] a);
        case (a)
            `CAP_ADDR_SEL:   capDecode = CAP_R_SEL;
            `CAP_ADDR_PULL1: capDecode = CAP_R_PULL1;
            `CAP_ADDR_PULL2: capDecode = CAP_R_PULL2;
            `CAP_ADDR_PULL3: capDecode = CAP_R_PULL3;
            default:         capDecode = CAP_R_NONE;
        endcase
    endfunction

    // one wait state: pready rises in the second access cycle
    always_comb begin
        hit       = capDecode(paddr);
        sel_d     = sel_q;
        pull1_d   = pull1_q;
        pull2_d   = pull2_q;
        pull3_d   = pull3_q;
        prdata_d  = prdata_q;
        pready_d  = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pslverr_d = (hit == CAP_R_NONE);
            case (hit)
                CAP_R_SEL:   prdata_d = {16'h0000, sel_q};
                CAP_R_PULL1: prdata_d = {16'h0000, pull1_q};
                CAP_R_PULL2: prdata_d = {16'h0000, pull2_q};
                CAP_R_PULL3: prdata_d = {16'h0000, pull3_q};
                default:     prdata_d = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pready_q && pwrite) begin
            case (hit)
                CAP_R_SEL:   sel_d   = pwdata[15:0];
                CAP_R_PULL1: pull1_d = pwdata[15:0];
                CAP_R_PULL2: pull2_d = pwdata[15:0];
                CAP_R_PULL3: pull3_d = pwdata[15:0];
                default:     sel_d   = sel_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q     <= `CAP_SEL_RST;
            pull1_q   <= `CAP_PULL_RST;
            pull2_q   <= `CAP_PULL_RST;
            pull3_q   <= `CAP_PULL_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            sel_q     <= sel_d;
            pull1_q   <= pull1_d;
            pull2_q   <= pull2_d;
            pull3_q   <= pull3_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pullBank2 = pull2_q;
    assign pullBank3 = pull3_q;

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    cap_mode_t mode0, mode1;
    cap_six_t  asel;
    cap_six_t  s0Out, s0Oe, s0Card, s0Gpio, s1Out, s1Oe, s1Card, s1Gpio;
    logic [3:0] s0Audio, s1Audio;

    assign mode0 = cap_mode_t'(sel_q[`CAP_SEL0_MSB:`CAP_SEL0_LSB]);
    assign mode1 = cap_mode_t'(sel_q[`CAP_SEL1_MSB:`CAP_SEL1_LSB]);
    assign asel  = sel_q[`CAP_ASEL_MSB:`CAP_ASEL_LSB];

    cap_pin_slice u_port0 (
        .mode     (mode0),
        .cardOut  (card0Out),
        .cardOe   (card0Oe),
        .cardIn   (s0Card),
        .audioOut (audio0Out),
        .audioOe  (audio0Oe),
        .audioIn  (s0Audio),
        .gpioOut  (gpioOut[5:0]),
        .gpioOe   (gpioOe[5:0]),
        .gpioIn   (s0Gpio),
        .pinIn    (p0PinIn),
        .pinOut   (s0Out),
        .pinOe    (s0Oe)
    );

    cap_pin_slice u_port1 (
        .mode     (mode1),
        .cardOut  (card1Out),
        .cardOe   (card1Oe),
        .cardIn   (s1Card),
        .audioOut (audio1Out),
        .audioOe  (audio1Oe),
        .audioIn  (s1Audio),
        .gpioOut  (gpioOut[11:6]),
        .gpioOe   (gpioOe[11:6]),
        .gpioIn   (s1Gpio),
        .pinIn    (p1PinIn),
        .pinOut   (s1Out),
        .pinOe    (s1Oe)
    );

    cap_six_t   p0Out_q, p0Out_d, p0Oe_q, p0Oe_d, p0Pd_q, p0Pd_d;
    cap_six_t   p1Out_q, p1Out_d, p1Oe_q, p1Oe_d, p1Pd_q, p1Pd_d;
    cap_six_t   c0In_q, c0In_d, c1In_q, c1In_d;
    logic [3:0] a0In_q, a0In_d, a1In_q, a1In_d;
    logic [11:0] gIn_q, gIn_d;
    cap_six_t   aOut_q, aOut_d, aOe_q, aOe_d, gHiIn_q, gHiIn_d;

    always_comb begin
        p0Out_d = s0Out;
        p0Oe_d  = s0Oe;
        p1Out_d = s1Out;
        p1Oe_d  = s1Oe;
        c0In_d  = s0Card;
        c1In_d  = s1Card;
        a0In_d  = s0Audio;
        a1In_d  = s1Audio;
        gIn_d   = {s1Gpio, s0Gpio};
        // pulldown follows its inhibit bit whatever the function
        p0Pd_d  = ~pull1_q[`CAP_PI0_MSB:`CAP_PI0_LSB];
        p1Pd_d  = ~pull1_q[`CAP_PI1_MSB:`CAP_PI1_LSB];
        aOut_d  = (asel & gpioHiOut) | (~asel & addrOut);
        aOe_d   = (asel & gpioHiOe) | (~asel & addrOe);
        gHiIn_d = asel & addrPinIn;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            p0Out_q <= 6'h00;
            p0Oe_q  <= 6'h00;
            p0Pd_q  <= 6'h3f;
            p1Out_q <= 6'h00;
            p1Oe_q  <= 6'h00;
            p1Pd_q  <= 6'h3f;
            c0In_q  <= 6'h00;
            c1In_q  <= 6'h00;
            a0In_q  <= 4'h0;
            a1In_q  <= 4'h0;
            gIn_q   <= 12'h000;
            aOut_q  <= 6'h00;
            aOe_q   <= 6'h00;
            gHiIn_q <= 6'h00;
        end else begin
            p0Out_q <= p0Out_d;
            p0Oe_q  <= p0Oe_d;
            p0Pd_q  <= p0Pd_d;
            p1Out_q <= p1Out_d;
            p1Oe_q  <= p1Oe_d;
            p1Pd_q  <= p1Pd_d;
            c0In_q  <= c0In_d;
            c1In_q  <= c1In_d;
            a0In_q  <= a0In_d;
            a1In_q  <= a1In_d;
            gIn_q   <= gIn_d;
            aOut_q  <= aOut_d;
            aOe_q   <= aOe_d;
            gHiIn_q <= gHiIn_d;
        end
    end

    assign p0PinOut     = p0Out_q;
    assign p0PinOe      = p0Oe_q;
    assign p0PullDownEn = p0Pd_q;
    assign p1PinOut     = p1Out_q;
    assign p1PinOe      = p1Oe_q;
    assign p1PullDownEn = p1Pd_q;
    assign card0In      = c0In_q;
    assign card1In      = c1In_q;
    assign audio0In     = a0In_q;
    assign audio1In     = a1In_q;
    assign gpioIn       = gIn_q;
    assign addrPinOut   = aOut_q;
    assign addrPinOe    = aOe_q;
    assign gpioHiIn     = gHiIn_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_port1_card_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode1 == CAP_MODE_CARD) |=> (p1PinOut == $past(card1Out)
            && p1PinOe == $past(card1Oe) && card1In == $past(p1PinIn)))
        else $error("port1 card routing wrong");
    a_port1_audio_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode1 == CAP_MODE_AUDIO) |=>
            (p1PinOut == {$past(gpioOut[11:10]), $past(audio1Out)}
            && gpioIn[11:10] == $past(p1PinIn[5:4])
            && card1In == 6'h00))
        else $error("port1 audio routing wrong");
    a_port1_gpio_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode1 == CAP_MODE_GPIO) ##1 1'b1 |->
            (p1PinOe == $past(gpioOe[11:6]) && gpioIn[11:6] == $past(p1PinIn)))
        else $error("port1 gpio routing wrong");
    a_port0_card_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode0 == CAP_MODE_CARD) |=> (p0PinOut == $past(card0Out)
            && audio0In == 4'h0 && card0In == $past(p0PinIn)))
        else $error("port0 card routing wrong");
    a_port0_audio_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode0 == CAP_MODE_AUDIO) |=>
            (p0PinOe == {$past(gpioOe[5:4]), $past(audio0Oe)}
            && audio0In == $past(p0PinIn[3:0])))
        else $error("port0 audio routing wrong");
    a_port0_gpio_route: assert property (@(posedge clk) disable iff (rst)
        (!rst && mode0 == CAP_MODE_GPIO) |=>
            (p0PinOut == $past(gpioOut[5:0]) && gpioIn[5:0] == $past(p0PinIn)))
        else $error("port0 gpio routing wrong");
    a_addr_pin_select: assert property (@(posedge clk) disable iff (rst)
        !rst |=> (addrPinOut == (($past(asel) & $past(gpioHiOut))
            | (~$past(asel) & $past(addrOut)))))
        else $error("address pin select wrong");
    a_pulldown_inhibit: assert property (@(posedge clk) disable iff (rst)
        (!rst && $changed(pull1_q)) |=> ({p1PullDownEn, p0PullDownEn}
            == ~$past(pull1_q[`CAP_PI1_MSB:`CAP_PI0_LSB])))
        else $error("pulldown enable does not follow inhibit");
    a_reserved_code: assert property (@(posedge clk) disable iff (rst)
        (!rst && (mode0 == CAP_MODE_RSVD || mode1 == CAP_MODE_RSVD)) |=>
            (($past(mode0) != CAP_MODE_RSVD || p0PinOut == $past(card0Out)) &&
            ($past(mode1) != CAP_MODE_RSVD || p1PinOut == $past(card1Out))))
        else $error("reserved code not card routing");
endmodule

//--- cap_pin_partner.sv
// far-side model of the card, codec or memory on six shared pins
`timescale 1ns/1ps
module cap_pin_partner (
    input  wire logic              clk,
    input  wire cap_pkg::cap_six_t pinOut,
    input  wire cap_pkg::cap_six_t pinOe,
    input  wire cap_pkg::cap_six_t pullEn,
    input  wire cap_pkg::cap_six_t extVal,
    input  wire cap_pkg::cap_six_t extOe,
    output cap_pkg::cap_six_t      pinIn
);
    import cap_pkg::*;
    // undriven pins without pulldown wander instead of holding a value
    cap_six_t float_q = 6'h15;
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
                 | (~pinOe & ~extOe & ~pullEn & float_q);
endmodule

//--- card_audio_addr_pin_mux_bench.sv
// self-checking bench of the card/audio/address pin multiplexer
`timescale 1ns/1ps
`include "cap_regs.svh"
module card_audio_addr_pin_mux_bench;
    import cap_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    cap_six_t    cardOut [2] = '{6'h2d, 6'h13};
    cap_six_t    cardOe [2] = '{6'h33, 6'h0e};
    cap_six_t    cardIn [2];
    logic [3:0]  audOut [2] = '{4'ha, 4'h5};
    logic [3:0]  audOe [2] = '{4'h6, 4'h9};
    logic [3:0]  audIn [2];
    logic [11:0] gpioOut = 12'h9c6;
    logic [11:0] gpioOe = 12'h5a3;
    logic [11:0] gpioIn;
    cap_six_t    pinIn [2];
    cap_six_t    pinOut [2];
    cap_six_t    pinOe [2];
    cap_six_t    pullEn [2];
    cap_six_t    extOe [2] = '{6'h00, 6'h00};
    cap_six_t    extVal [2] = '{6'h1b, 6'h26};
    cap_six_t    addrOut = 6'h19;
    cap_six_t    addrOe = 6'h2e;
    cap_six_t    hiOut = 6'h34;
    cap_six_t    hiOe = 6'h13;
    cap_six_t    hiIn;
    cap_six_t    aPinIn;
    cap_six_t    aPinOut;
    cap_six_t    aPinOe;
    cap_six_t    aExtOe = 6'h00;
    cap_six_t    aExtVal = 6'h0b;
    cap_word_t   pullBank2;
    cap_word_t   pullBank3;
    int          numErrors = 0;
    int          nCompared = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    cap_pin_mux i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .card0Out(cardOut[0]), .card0Oe(cardOe[0]), .card0In(cardIn[0]),
        .audio0Out(audOut[0]), .audio0Oe(audOe[0]), .audio0In(audIn[0]),
        .card1Out(cardOut[1]), .card1Oe(cardOe[1]), .card1In(cardIn[1]),
        .audio1Out(audOut[1]), .audio1Oe(audOe[1]), .audio1In(audIn[1]),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn),
        .p0PinIn(pinIn[0]), .p0PinOut(pinOut[0]), .p0PinOe(pinOe[0]),
        .p0PullDownEn(pullEn[0]), .p1PinIn(pinIn[1]),
        .p1PinOut(pinOut[1]), .p1PinOe(pinOe[1]),
        .p1PullDownEn(pullEn[1]), .addrOut(addrOut), .addrOe(addrOe),
        .gpioHiOut(hiOut), .gpioHiOe(hiOe), .gpioHiIn(hiIn),
        .addrPinIn(aPinIn), .addrPinOut(aPinOut), .addrPinOe(aPinOe),
        .pullBank2(pullBank2), .pullBank3(pullBank3)
    );

    for (genvar p = 0; p < 2; p++) begin : g_port
        cap_pin_partner i_far (
            .clk(clk), .pinOut(pinOut[p]), .pinOe(pinOe[p]),
            .pullEn(pullEn[p]), .extVal(extVal[p]), .extOe(extOe[p]),
            .pinIn(pinIn[p]));
    end
    cap_pin_partner i_mem (
        .clk(clk), .pinOut(aPinOut), .pinOe(aPinOe), .pullEn(6'h3f),
        .extVal(aExtVal), .extOe(aExtOe), .pinIn(aPinIn));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(logic w, logic [15:0] a, logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [15:0] a, logic [31:0] d, logic eExp);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check("write pslverr", 32'(e), 32'(eExp));
    endtask

    task automatic rd(logic [15:0] a, logic [31:0] exp, logic eExp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check("prdata", r, exp);
        check("read pslverr", 32'(e), 32'(eExp));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        check("pulldown0", 32'(pullEn[0]), 32'h3f);
        check("pulldown1", 32'(pullEn[1]), 32'h3f);
        rd(`CAP_ADDR_SEL, 32'h0, 1'b0);
        rd(`CAP_ADDR_PULL1, 32'h0, 1'b0);
        rd(`CAP_ADDR_PULL2, 32'h0, 1'b0);
        rd(`CAP_ADDR_PULL3, 32'h0, 1'b0);
    endtask

    task automatic test_modes();
        logic [1:0] m;
        cap_six_t   g;
        cap_six_t   ge;
        cap_six_t   eo;
        cap_six_t   eoe;
        cap_six_t   w;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                m = k[1:0];
                // after each routing change the far side drives only the pins that the new routing leaves undriven
                wr(`CAP_ADDR_SEL, 32'(m) << (2 * p), 1'b0);
                g = gpioOut[6 * p +: 6];
                ge = gpioOe[6 * p +: 6];
                eo = (m == 2'b10) ? g
                   : (m == 2'b01) ? {g[5:4], audOut[p]} : cardOut[p];
                eoe = (m == 2'b10) ? ge
                    : (m == 2'b01) ? {ge[5:4], audOe[p]} : cardOe[p];
                extOe[p] <= ~eoe;
                repeat (4) @(posedge clk);
                w = (eoe & eo) | (~eoe & extVal[p]);
                check("pinOut", 32'(pinOut[p]), 32'(eo));
                check("pinOe", 32'(pinOe[p]), 32'(eoe));
                check("cardIn", 32'(cardIn[p]),
                      32'((m == 2'b01 || m == 2'b10) ? 6'h0 : w));
                check("audioIn", 32'(audIn[p]),
                      32'((m == 2'b01) ? w[3:0] : 4'h0));
                check("gpioIn", 32'(gpioIn[6 * p +: 6]),
                      32'((m == 2'b10) ? w
                        : (m == 2'b01) ? {w[5:4], 4'h0} : 6'h0));
            end
        end
    endtask

    task automatic test_addr();
        cap_six_t s;
        cap_six_t eo;
        cap_six_t eoe;
        cap_six_t w;
        for (int k = 1; k < 4; k++) begin
            s = 6'(k * 21);
            wr(`CAP_ADDR_SEL, 32'(s) << `CAP_ASEL_LSB, 1'b0);
            eo = (s & hiOut) | (~s & addrOut);
            eoe = (s & hiOe) | (~s & addrOe);
            aExtOe <= ~eoe;
            repeat (4) @(posedge clk);
            w = (eoe & eo) | (~eoe & aExtVal);
            check("addrPinOut", 32'(aPinOut), 32'(eo));
            check("addrPinOe", 32'(aPinOe), 32'(eoe));
            check("gpioHiIn", 32'(hiIn), 32'(s & w));
        end
    endtask

    task automatic test_pull();
        logic [11:0] d;
        d = 12'ha5c;
        // pins with an external resistor get their pulldown inhibited
        wr(`CAP_ADDR_PULL1, {16'hffff, 4'h0, d}, 1'b0);
        repeat (2) @(posedge clk);
        check("pulldown0", 32'(pullEn[0]), 32'(cap_six_t'(~d[5:0])));
        check("pulldown1", 32'(pullEn[1]), 32'(cap_six_t'(~d[11:6])));
        rd(`CAP_ADDR_PULL1, {20'h0, d}, 1'b0);
        wr(`CAP_ADDR_PULL2, 32'h0000_c3a5, 1'b0);
        wr(`CAP_ADDR_PULL3, 32'h0000_5a3c, 1'b0);
        repeat (2) @(posedge clk);
        check("pullBank2", 32'(pullBank2), 32'h0000_c3a5);
        check("pullBank3", 32'(pullBank3), 32'h0000_5a3c);
        wr(16'h7068, 32'h0000_ffff, 1'b1);
        rd(16'h7068, 32'h0, 1'b1);
        rd(`CAP_ADDR_PULL3, 32'h0000_5a3c, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("pulldown0", 32'(pullEn[0]), 32'h3f);
        check("pullBank2 reset", 32'(pullBank2), 32'h0);
        rd(`CAP_ADDR_PULL1, 32'h0, 1'b0);
        rd(`CAP_ADDR_SEL, 32'h0, 1'b0);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            numErrors++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_modes();
        test_addr();
        test_pull();
        final_report();
    end
endmodule
